// ### hdl/ptev_pkg.sv
// Constants, field layouts and types for the pin task and event unit
package ptev_pkg;
  localparam int NUM_CH = 8;
  localparam int NUM_PINS = 32;
  localparam int NUM_ROUTES = 256;
  localparam int ADDR_W = 12;
  localparam int IDX_W = 3;
  localparam int ROUTING_CHANNEL_INDEX_W = 8;
  localparam int PSEL_W = 5;
  localparam logic [11:0] OFS_SUB_WRITE = 12'h080;
  localparam logic [11:0] OFS_SUB_HIGH = 12'h0b0;
  localparam logic [11:0] OFS_SUB_LOW = 12'h0e0;
  localparam logic [11:0] OFS_EDGE_FLAG = 12'h100;
  localparam logic [11:0] OFS_SENSE_FLAG = 12'h17c;
  localparam logic [11:0] OFS_EDGE_PUB = 12'h180;
  localparam logic [11:0] OFS_SENSE_PUB = 12'h1fc;
  localparam logic [11:0] OFS_INT_SET = 12'h304;
  localparam logic [11:0] OFS_INT_CLR = 12'h308;
  localparam logic [11:0] OFS_CONFIG = 12'h510;
  localparam logic [11:0] ARRAY_SPAN = 12'h020;
  localparam int ROUTING_CHANNEL_INDEX_LSB = 0;
  localparam int EN_BIT = 31;
  localparam int FLAG_BIT = 0;
  localparam int SENSE_INT_BIT = 31;
  localparam int MODE_LSB = 0;
  localparam int PSEL_LSB = 8;
  localparam int POL_LSB = 16;
  localparam int INIT_BIT = 20;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  typedef enum logic [1:0] {
    PTEV_MODE_OFF = 2'b00,
    PTEV_MODE_EVENT = 2'b01,
    PTEV_MODE_TASK = 2'b11
  } ptev_mode_type;
  typedef enum logic [1:0] {
    PTEV_POL_NONE = 2'b00,
    PTEV_POL_HIGH = 2'b01,
    PTEV_POL_LOW = 2'b10,
    PTEV_POL_TOGGLE = 2'b11
  } ptev_pol_type;
endpackage : ptev_pkg

// ### hdl/ptev_top.sv
// Pin task and event unit with Avalon-MM register slave
`timescale 1ns/1ps
module ptev_top (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [11:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic [255:0] route_fire_i,
  output logic [255:0] route_publish_o,
  input wire logic [31:0] pin_in_i,
  input wire logic [31:0] gpio_out_i,
  input wire logic [31:0] gpio_oe_n_i,
  input wire logic sense_detect_i,
  output logic [31:0] pin_out_o,
  output logic [31:0] pin_oe_n_o,
  output logic irq_o
);
  localparam int NCH = ptev_pkg::NUM_CH;
  localparam int CW = ptev_pkg::ROUTING_CHANNEL_INDEX_W;

  logic wait_q;
  logic [31:0] rdata_q;
  logic [CW-1:0] sub_w_ch_q [NCH];
  logic [CW-1:0] sub_h_ch_q [NCH];
  logic [CW-1:0] sub_l_ch_q [NCH];
  logic [CW-1:0] pub_ch_q [NCH];
  logic [NCH-1:0] sub_w_en_q, sub_h_en_q, sub_l_en_q, pub_en_q;
  logic [CW-1:0] sense_pub_ch_q;
  logic sense_pub_en_q;
  ptev_pkg::ptev_mode_type mode_q [NCH];
  ptev_pkg::ptev_pol_type pol_q [NCH];
  logic [ptev_pkg::PSEL_W-1:0] psel_q [NCH];
  logic [NCH-1:0] init_q, lvl_q, prev_q, flag_q, inten_q;
  logic sense_flag_q, sense_inten_q;
  logic [31:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_f_q;
  logic det_s1_q, det_s2_q, det_s3_q, det_f_q, det_old_q;
  logic [31:0] pin_out_q, pin_oe_n_q;
  logic [255:0] pub_q;
  logic irq_q;
  logic [31:0] rd_word, wmerge, wset;
  logic wr_acc;
  logic [NCH-1:0] fire_w, fire_h, fire_l, edge_hit, cfg_wr;
  logic sense_rise;

  // Window test for one of the eight-word register arrays
  function automatic logic arr_hit(input logic [11:0] a, input logic [11:0] base);
    return (a >= base) && (a < 12'(base + ptev_pkg::ARRAY_SPAN)) && (a[1:0] == 2'b00);
  endfunction : arr_hit

  function automatic logic [2:0] arr_idx(input logic [11:0] a, input logic [11:0] base);
    logic [11:0] d;
    d = 12'(a - base);
    return d[4:2];
  endfunction : arr_idx

  function automatic logic [31:0] route_word(input logic [7:0] ch, input logic en);
    logic [31:0] w;
    w = ptev_pkg::WORD_ZERO;
    w[ptev_pkg::ROUTING_CHANNEL_INDEX_LSB +: ptev_pkg::ROUTING_CHANNEL_INDEX_W] = ch;
    w[ptev_pkg::EN_BIT] = en;
    return w;
  endfunction : route_word

  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : lane_mask

  // Bus slave: one wait cycle, then the access completes
  assign wr_acc = avs_write_i && !wait_q;
  assign wset = avs_writedata_i & lane_mask(avs_byteenable_i);
  assign wmerge = (rd_word & ~lane_mask(avs_byteenable_i)) | wset;

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      wait_q <= 1'b1;
    end else if ((avs_read_i || avs_write_i) && wait_q) begin
      wait_q <= 1'b0;
    end else begin
      wait_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      rdata_q <= ptev_pkg::WORD_ZERO;
    end else if (avs_read_i && wait_q) begin
      rdata_q <= rd_word;
    end
  end

  // Unmapped addresses read zero and ignore writes
  always_comb begin
    logic [11:0] a;
    logic [2:0] i;
    a = avs_address_i;
    rd_word = ptev_pkg::WORD_ZERO;
    i = 3'b000;
    if (arr_hit(a, ptev_pkg::OFS_SUB_WRITE)) begin
      i = arr_idx(a, ptev_pkg::OFS_SUB_WRITE);
      rd_word = route_word(sub_w_ch_q[i], sub_w_en_q[i]);
    end else if (arr_hit(a, ptev_pkg::OFS_SUB_HIGH)) begin
      i = arr_idx(a, ptev_pkg::OFS_SUB_HIGH);
      rd_word = route_word(sub_h_ch_q[i], sub_h_en_q[i]);
    end else if (arr_hit(a, ptev_pkg::OFS_SUB_LOW)) begin
      i = arr_idx(a, ptev_pkg::OFS_SUB_LOW);
      rd_word = route_word(sub_l_ch_q[i], sub_l_en_q[i]);
    end else if (arr_hit(a, ptev_pkg::OFS_EDGE_FLAG)) begin
      i = arr_idx(a, ptev_pkg::OFS_EDGE_FLAG);
      rd_word[ptev_pkg::FLAG_BIT] = flag_q[i];
    end else if (a == ptev_pkg::OFS_SENSE_FLAG) begin
      rd_word[ptev_pkg::FLAG_BIT] = sense_flag_q;
    end else if (arr_hit(a, ptev_pkg::OFS_EDGE_PUB)) begin
      i = arr_idx(a, ptev_pkg::OFS_EDGE_PUB);
      rd_word = route_word(pub_ch_q[i], pub_en_q[i]);
    end else if (a == ptev_pkg::OFS_SENSE_PUB) begin
      rd_word = route_word(sense_pub_ch_q, sense_pub_en_q);
    end else if (a == ptev_pkg::OFS_INT_SET || a == ptev_pkg::OFS_INT_CLR) begin
      rd_word[NCH-1:0] = inten_q;
      rd_word[ptev_pkg::SENSE_INT_BIT] = sense_inten_q;
    end else if (arr_hit(a, ptev_pkg::OFS_CONFIG)) begin
      i = arr_idx(a, ptev_pkg::OFS_CONFIG);
      rd_word[ptev_pkg::MODE_LSB +: 2] = mode_q[i];
      rd_word[ptev_pkg::PSEL_LSB +: ptev_pkg::PSEL_W] = psel_q[i];
      rd_word[ptev_pkg::POL_LSB +: 2] = pol_q[i];
      rd_word[ptev_pkg::INIT_BIT] = init_q[i];
    end
  end

  // Pin and detect synchronisers; a change counts once stages two and three agree
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      pin_s1_q <= ptev_pkg::WORD_ZERO;
      pin_s2_q <= ptev_pkg::WORD_ZERO;
      pin_s3_q <= ptev_pkg::WORD_ZERO;
      pin_f_q <= ptev_pkg::WORD_ZERO;
      det_s1_q <= 1'b0;
      det_s2_q <= 1'b0;
      det_s3_q <= 1'b0;
      det_f_q <= 1'b0;
      det_old_q <= 1'b0;
    end else begin
      pin_s1_q <= pin_in_i;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pin_f_q <= (pin_s2_q & ~(pin_s2_q ^ pin_s3_q)) | (pin_f_q & (pin_s2_q ^ pin_s3_q));
      det_s1_q <= sense_detect_i;
      det_s2_q <= det_s1_q;
      det_s3_q <= det_s2_q;
      det_f_q <= (det_s2_q == det_s3_q) ? det_s2_q : det_f_q;
      det_old_q <= det_f_q;
    end
  end

  assign sense_rise = det_f_q && !det_old_q;

  // Task triggers, edge detection and configuration writes per channel
  always_comb begin
    logic cur;
    cur = 1'b0;
    for (int n = 0; n < NCH; n++) begin
      fire_w[n] = sub_w_en_q[n] && route_fire_i[sub_w_ch_q[n]];
      fire_h[n] = sub_h_en_q[n] && route_fire_i[sub_h_ch_q[n]];
      fire_l[n] = sub_l_en_q[n] && route_fire_i[sub_l_ch_q[n]];
      cfg_wr[n] = wr_acc && arr_hit(avs_address_i, ptev_pkg::OFS_CONFIG)
        && (arr_idx(avs_address_i, ptev_pkg::OFS_CONFIG) == 3'(n));
      cur = pin_f_q[psel_q[n]];
      edge_hit[n] = 1'b0;
      if (mode_q[n] == ptev_pkg::PTEV_MODE_EVENT) begin
        case (pol_q[n])
          ptev_pkg::PTEV_POL_HIGH: edge_hit[n] = cur && !prev_q[n];
          ptev_pkg::PTEV_POL_LOW: edge_hit[n] = !cur && prev_q[n];
          ptev_pkg::PTEV_POL_TOGGLE: edge_hit[n] = cur ^ prev_q[n];
          default: edge_hit[n] = 1'b0;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      prev_q <= '0;
    end else begin
      for (int n = 0; n < NCH; n++) begin
        prev_q[n] <= pin_f_q[psel_q[n]];
      end
    end
  end

  // Routing registers: subscriptions and publish settings
  always_ff @(posedge clk_i) begin
    logic [2:0] i;
    i = arr_idx(avs_address_i, ptev_pkg::OFS_SUB_WRITE);
    if (!nrst_i) begin
      for (int n = 0; n < NCH; n++) begin
        sub_w_ch_q[n] <= '0;
        sub_h_ch_q[n] <= '0;
        sub_l_ch_q[n] <= '0;
        pub_ch_q[n] <= '0;
      end
      sub_w_en_q <= '0;
      sub_h_en_q <= '0;
      sub_l_en_q <= '0;
      pub_en_q <= '0;
      sense_pub_ch_q <= '0;
      sense_pub_en_q <= 1'b0;
    end else if (wr_acc) begin
      if (arr_hit(avs_address_i, ptev_pkg::OFS_SUB_WRITE)) begin
        sub_w_ch_q[i] <= wmerge[ptev_pkg::ROUTING_CHANNEL_INDEX_LSB +: CW];
        sub_w_en_q[i] <= wmerge[ptev_pkg::EN_BIT];
      end
      if (arr_hit(avs_address_i, ptev_pkg::OFS_SUB_HIGH)) begin
        i = arr_idx(avs_address_i, ptev_pkg::OFS_SUB_HIGH);
        sub_h_ch_q[i] <= wmerge[ptev_pkg::ROUTING_CHANNEL_INDEX_LSB +: CW];
        sub_h_en_q[i] <= wmerge[ptev_pkg::EN_BIT];
      end
      if (arr_hit(avs_address_i, ptev_pkg::OFS_SUB_LOW)) begin
        i = arr_idx(avs_address_i, ptev_pkg::OFS_SUB_LOW);
        sub_l_ch_q[i] <= wmerge[ptev_pkg::ROUTING_CHANNEL_INDEX_LSB +: CW];
        sub_l_en_q[i] <= wmerge[ptev_pkg::EN_BIT];
      end
      if (arr_hit(avs_address_i, ptev_pkg::OFS_EDGE_PUB)) begin
        i = arr_idx(avs_address_i, ptev_pkg::OFS_EDGE_PUB);
        pub_ch_q[i] <= wmerge[ptev_pkg::ROUTING_CHANNEL_INDEX_LSB +: CW];
        pub_en_q[i] <= wmerge[ptev_pkg::EN_BIT];
      end
      if (avs_address_i == ptev_pkg::OFS_SENSE_PUB) begin
        sense_pub_ch_q <= wmerge[ptev_pkg::ROUTING_CHANNEL_INDEX_LSB +: CW];
        sense_pub_en_q <= wmerge[ptev_pkg::EN_BIT];
      end
    end
  end

  // Channel configuration; the pin select only moves while the channel is off
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      for (int n = 0; n < NCH; n++) begin
        mode_q[n] <= ptev_pkg::PTEV_MODE_OFF;
        pol_q[n] <= ptev_pkg::PTEV_POL_NONE;
        psel_q[n] <= '0;
      end
      init_q <= '0;
    end else begin
      for (int n = 0; n < NCH; n++) begin
        if (cfg_wr[n]) begin
          mode_q[n] <= ptev_pkg::ptev_mode_type'(wmerge[ptev_pkg::MODE_LSB +: 2]);
          pol_q[n] <= ptev_pkg::ptev_pol_type'(wmerge[ptev_pkg::POL_LSB +: 2]);
          init_q[n] <= wmerge[ptev_pkg::INIT_BIT];
          if (mode_q[n] == ptev_pkg::PTEV_MODE_OFF) begin
            psel_q[n] <= wmerge[ptev_pkg::PSEL_LSB +: ptev_pkg::PSEL_W];
          end
        end
      end
    end
  end

  // Output level each channel holds for its pin in task mode
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      lvl_q <= '0;
    end else begin
      for (int n = 0; n < NCH; n++) begin
        if (cfg_wr[n]) begin
          lvl_q[n] <= wmerge[ptev_pkg::INIT_BIT];
        end else if (mode_q[n] == ptev_pkg::PTEV_MODE_TASK) begin
          if (fire_w[n]) begin
            case (pol_q[n])
              ptev_pkg::PTEV_POL_HIGH: lvl_q[n] <= 1'b1;
              ptev_pkg::PTEV_POL_LOW: lvl_q[n] <= 1'b0;
              ptev_pkg::PTEV_POL_TOGGLE: lvl_q[n] <= ~lvl_q[n];
              default: lvl_q[n] <= lvl_q[n];
            endcase
          end else if (fire_l[n]) begin
            lvl_q[n] <= 1'b0;
          end else if (fire_h[n]) begin
            lvl_q[n] <= 1'b1;
          end
        end
      end
    end
  end

  // Pin ownership; overlapping pin selects are not arbitrated
  always_ff @(posedge clk_i) begin
    logic [31:0] o_d, oe_d;
    o_d = gpio_out_i;
    oe_d = gpio_oe_n_i;
    for (int n = 0; n < NCH; n++) begin
      if (mode_q[n] == ptev_pkg::PTEV_MODE_TASK) begin
        o_d[psel_q[n]] = lvl_q[n];
        oe_d[psel_q[n]] = 1'b0;
      end else if (mode_q[n] == ptev_pkg::PTEV_MODE_EVENT) begin
        oe_d[psel_q[n]] = 1'b1;
      end
    end
    if (!nrst_i) begin
      pin_out_q <= ptev_pkg::WORD_ZERO;
      pin_oe_n_q <= ~ptev_pkg::WORD_ZERO;
    end else begin
      pin_out_q <= o_d;
      pin_oe_n_q <= oe_d;
    end
  end

  // Event flags; hardware set wins over a software write in the same cycle
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      flag_q <= '0;
      sense_flag_q <= 1'b0;
    end else begin
      for (int n = 0; n < NCH; n++) begin
        if (edge_hit[n]) begin
          flag_q[n] <= 1'b1;
        end else if (wr_acc && arr_hit(avs_address_i, ptev_pkg::OFS_EDGE_FLAG)
            && arr_idx(avs_address_i, ptev_pkg::OFS_EDGE_FLAG) == 3'(n)) begin
          flag_q[n] <= wmerge[ptev_pkg::FLAG_BIT];
        end
      end
      if (sense_rise) begin
        sense_flag_q <= 1'b1;
      end else if (wr_acc && avs_address_i == ptev_pkg::OFS_SENSE_FLAG) begin
        sense_flag_q <= wmerge[ptev_pkg::FLAG_BIT];
      end
    end
  end

  // Interrupt enables through set and clear registers
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      inten_q <= '0;
      sense_inten_q <= 1'b0;
    end else if (wr_acc && avs_address_i == ptev_pkg::OFS_INT_SET) begin
      inten_q <= inten_q | wset[NCH-1:0];
      sense_inten_q <= sense_inten_q | wset[ptev_pkg::SENSE_INT_BIT];
    end else if (wr_acc && avs_address_i == ptev_pkg::OFS_INT_CLR) begin
      inten_q <= inten_q & ~wset[NCH-1:0];
      sense_inten_q <= sense_inten_q & ~wset[ptev_pkg::SENSE_INT_BIT];
    end
  end

  // Publishing and interrupt output
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      pub_q <= '0;
      irq_q <= 1'b0;
    end else begin
      pub_q <= '0;
      for (int n = 0; n < NCH; n++) begin
        if (edge_hit[n] && pub_en_q[n]) begin
          pub_q[pub_ch_q[n]] <= 1'b1;
        end
      end
      if (sense_rise && sense_pub_en_q) begin
        pub_q[sense_pub_ch_q] <= 1'b1;
      end
      irq_q <= |(flag_q & inten_q) || (sense_flag_q && sense_inten_q);
    end
  end

  assign avs_waitrequest_o = wait_q;
  assign avs_readdata_o = rdata_q;
  assign route_publish_o = pub_q;
  assign pin_out_o = pin_out_q;
  assign pin_oe_n_o = pin_oe_n_q;
  assign irq_o = irq_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  sequence s_task_held;
    (mode_q[0] == ptev_pkg::PTEV_MODE_TASK) [*2];
  endsequence
  sequence s_event_held;
    (mode_q[0] == ptev_pkg::PTEV_MODE_EVENT) [*2];
  endsequence

  property p_write_high;
    mode_q[0] == ptev_pkg::PTEV_MODE_TASK && fire_w[0] && !cfg_wr[0]
      && pol_q[0] == ptev_pkg::PTEV_POL_HIGH |=> lvl_q[0];
  endproperty
  a_write_high: assert property (p_write_high) else $error("write task did not drive high");
  property p_low_over_high;
    mode_q[0] == ptev_pkg::PTEV_MODE_TASK && !fire_w[0] && fire_l[0] && !cfg_wr[0] |=> !lvl_q[0];
  endproperty
  a_low_over_high: assert property (p_low_over_high) else $error("low task lost");
  property p_edge_flag;
    edge_hit[1] |=> flag_q[1] ##1 irq_o || !inten_q[1];
  endproperty
  a_edge_flag: assert property (p_edge_flag) else $error("edge flag not raised");
  property p_sense_pub;
    sense_rise && sense_pub_en_q |=> route_publish_o[$past(sense_pub_ch_q)];
  endproperty
  a_sense_pub: assert property (p_sense_pub) else $error("sense event not published");
  property p_int_set;
    wr_acc && avs_address_i == ptev_pkg::OFS_INT_SET && wset[0] |=> inten_q[0];
  endproperty
  a_int_set: assert property (p_int_set) else $error("interrupt enable not set");
  property p_int_clr;
    wr_acc && avs_address_i == ptev_pkg::OFS_INT_CLR && wset[0] |=> !inten_q[0];
  endproperty
  a_int_clr: assert property (p_int_clr) else $error("interrupt enable not cleared");
  property p_task_drive;
    s_task_held |-> !pin_oe_n_o[psel_q[0]] && pin_out_o[psel_q[0]] == $past(lvl_q[0]);
  endproperty
  a_task_drive: assert property (p_task_drive) else $error("task pin not driven");
  property p_event_input;
    s_event_held |-> pin_oe_n_o[psel_q[0]];
  endproperty
  a_event_input: assert property (p_event_input) else $error("event pin not input");
  property p_irq;
    (|(flag_q & inten_q)) |=> irq_o;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");
  property p_bus_answer;
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");
endmodule : ptev_top

// ### bench/ptev_fabric_model.sv
// Model of the routing fabric and the pin levels around the unit
`timescale 1ns/1ps
module ptev_fabric_model (
  input wire logic clk_i,
  input wire logic [255:0] route_publish_i,
  output logic [255:0] route_fire_o,
  output logic [31:0] pin_o
);
  int pub_cnt [256];
  initial begin
    route_fire_o = '0;
    pin_o = '0;
    foreach (pub_cnt[i]) pub_cnt[i] = 0;
  end
  // Fabric pulses last exactly one cycle
  task automatic fire(input logic [255:0] m);
    @(posedge clk_i);
    route_fire_o <= m;
    @(posedge clk_i);
    route_fire_o <= '0;
  endtask : fire
  task automatic drive_pin(input int p, input logic v);
    @(posedge clk_i);
    pin_o[p] <= v;
  endtask : drive_pin
  // Counts publish pulses per routing channel
  always @(posedge clk_i) begin
    for (int i = 0; i < 256; i++) if (route_publish_i[i] === 1'b1) pub_cnt[i]++;
  end
endmodule : ptev_fabric_model

// ### bench/test_ptev_top.sv
// Self-checking testbench for the pin task and event unit
`timescale 1ns/1ps
module test_ptev_top;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [11:0] addr = 12'h000;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata, pout, poen, pins, got;
  logic [255:0] fire, publ;
  logic waitreq, irq;
  logic [31:0] gout = 32'h0000_0000;
  logic [31:0] goen = 32'hffff_ffff;
  logic sense = 1'b0;
  int fail_count = 0;
  int check_count = 0;
  int cycles = 0;
  always #10 clk_i = ~clk_i;
  ptev_top dut (.clk_i(clk_i), .nrst_i(nrst_i), .avs_address_i(addr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(4'hf),
    .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq), .route_fire_i(fire),
    .route_publish_o(publ), .pin_in_i(pins), .gpio_out_i(gout), .gpio_oe_n_i(goen),
    .sense_detect_i(sense), .pin_out_o(pout), .pin_oe_n_o(poen), .irq_o(irq));
  ptev_fabric_model m (.clk_i(clk_i), .route_publish_i(publ), .route_fire_o(fire),
    .pin_o(pins));
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim
  // Hang guard, well above the few hundred cycles needed
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      end_sim();
    end
  end
  // Request holds until waitrequest is sampled low
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    rd <= ~w;
    wr <= w;
    do @(posedge clk_i); while (waitreq !== 1'b0);
    got = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic cw(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH at %0t: word %h expected %h", $time, g, e);
    end
  endtask : cw
  task automatic cb(input logic g, input logic e);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH at %0t: bit %b expected %b", $time, g, e);
    end
  endtask : cb
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    cw(got, e);
  endtask : rchk
  function automatic logic [31:0] cfg(input logic [1:0] md, input logic [4:0] p,
    input logic [1:0] pol, input logic ini);
    return {11'h000, ini, 2'b00, pol, 3'b000, p, 6'h00, md};
  endfunction : cfg
  task automatic fire_wait(input logic [255:0] f);
    m.fire(f);
    repeat (3) @(posedge clk_i);
  endtask : fire_wait
  task automatic t_regs();
    rchk(ptev_pkg::OFS_INT_SET, 32'h0000_0000);
    rchk(12'h400, 32'h0000_0000);
    bus(1'b1, ptev_pkg::OFS_INT_SET, 32'h8000_0003);
    rchk(ptev_pkg::OFS_INT_SET, 32'h8000_0003);
    bus(1'b1, ptev_pkg::OFS_INT_CLR, 32'h0000_0001);
    rchk(ptev_pkg::OFS_INT_CLR, 32'h8000_0002);
    bus(1'b1, ptev_pkg::OFS_INT_CLR, 32'h8000_0000);
    bus(1'b1, ptev_pkg::OFS_INT_SET, 32'h0000_0000);
    rchk(ptev_pkg::OFS_INT_SET, 32'h0000_0002);
    $display("interrupt enable test done");
  endtask : t_regs
  task automatic t_task();
    logic e;
    @(posedge clk_i);
    gout[5] <= 1'b1;
    goen[5] <= 1'b0;
    repeat (3) @(posedge clk_i);
    cb(pout[5], 1'b1);
    bus(1'b1, ptev_pkg::OFS_SUB_WRITE, 32'h8000_000c);
    bus(1'b1, ptev_pkg::OFS_SUB_HIGH, 32'h8000_000a);
    bus(1'b1, ptev_pkg::OFS_SUB_LOW, 32'h8000_000b);
    // Polarity codes in turn; pin chosen while the channel is off
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, ptev_pkg::OFS_CONFIG, cfg(2'b11, 5'd5, k[1:0], k[1]));
      repeat (3) @(posedge clk_i);
      cb(pout[5], k[1]);
      cb(poen[5], 1'b0);
      fire_wait(256'h1000);
      // None keeps the low initial level; high sets; low and toggle both end low
      e = (k == 1);
      cb(pout[5], e);
    end
    fire_wait(256'h1800);
    cb(pout[5], 1'b1);
    fire_wait(256'h0c00);
    cb(pout[5], 1'b0);
    fire_wait(256'h0400);
    cb(pout[5], 1'b1);
    fire_wait(256'h0800);
    cb(pout[5], 1'b0);
    cb(pout[5], 1'b0);
    $display("task mode test done");
  endtask : t_task
  task automatic t_event();
    @(posedge clk_i);
    goen[7] <= 1'b0;
    bus(1'b1, ptev_pkg::OFS_EDGE_PUB + 12'h004, 32'h8000_0014);
    bus(1'b1, ptev_pkg::OFS_CONFIG + 12'h004, cfg(2'b01, 5'd7, 2'b01, 1'b1));
    repeat (3) @(posedge clk_i);
    cb(poen[7], 1'b1);
    m.drive_pin(7, 1'b1);
    repeat (12) @(posedge clk_i);
    rchk(ptev_pkg::OFS_EDGE_FLAG + 12'h004, 32'h0000_0001);
    cw(32'(m.pub_cnt[20]), 32'h0000_0001);
    cb(irq, 1'b1);
    bus(1'b1, ptev_pkg::OFS_EDGE_FLAG + 12'h004, 32'h0000_0000);
    rchk(ptev_pkg::OFS_EDGE_FLAG + 12'h004, 32'h0000_0000);
    cb(irq, 1'b0);
    m.drive_pin(7, 1'b0);
    repeat (12) @(posedge clk_i);
    rchk(ptev_pkg::OFS_EDGE_FLAG + 12'h004, 32'h0000_0000);
    bus(1'b1, ptev_pkg::OFS_CONFIG + 12'h004, cfg(2'b01, 5'd7, 2'b11, 1'b0));
    m.drive_pin(7, 1'b1);
    repeat (12) @(posedge clk_i);
    rchk(ptev_pkg::OFS_EDGE_FLAG + 12'h004, 32'h0000_0001);
    bus(1'b1, ptev_pkg::OFS_EDGE_FLAG + 12'h004, 32'h0000_0000);
    $display("event mode test done");
  endtask : t_event
  task automatic t_sense();
    bus(1'b1, ptev_pkg::OFS_SENSE_PUB, 32'h8000_001e);
    bus(1'b1, ptev_pkg::OFS_INT_SET, 32'h8000_0000);
    @(posedge clk_i);
    sense <= 1'b1;
    repeat (12) @(posedge clk_i);
    rchk(ptev_pkg::OFS_SENSE_FLAG, 32'h0000_0001);
    cw(32'(m.pub_cnt[30]), 32'h0000_0001);
    cb(irq, 1'b1);
    $display("sense event test done");
  endtask : t_sense
  initial begin
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
    t_regs();
    t_task();
    t_event();
    t_sense();
    end_sim();
  end
endmodule : test_ptev_top
